//--- verilog/dcr_defines.svh
// Offsets, field positions, reset values and write masks of the channel register set
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH

// ****************************************
// Register map (byte addresses, low 7 bits)
// ****************************************
`define DCR_CH0_BASE     7'h20
`define DCR_CH_LAST      7'h5F
`define DCR_SEL_SRC      2'h0
`define DCR_SEL_DST      2'h1
`define DCR_SEL_CNT      2'h2
`define DCR_SEL_CTL      2'h3

// ****************************************
// Channel control fields
// ****************************************
`define DCR_BIT_END_FLAG   1
`define DCR_BIT_REQ_SENSE  6
`define DCR_BIT_STB_POL    16
`define DCR_BIT_ACK_PHASE  17
`define DCR_BIT_ACC_POL    18
`define DCR_BIT_SRC_RELOAD 19
`define DCR_BIT_PTR_MODE   20
`define DCR_CTL_RST      32'h00000000
`define DCR_MASK_CH01    32'h0007FF7D
`define DCR_MASK_CH2     32'h0008FF3D
`define DCR_MASK_CH3     32'h0010FF3D
`define DCR_CNT_MASK     32'h00FFFFFF

// ****************************************
// Reload period on channel 2 (transfers minus one)
// ****************************************
`define DCR_RELOAD_LAST  2'h3

`endif

//--- verilog/dcr_pkg.sv
// Types shared by the channel register set
package dcr_pkg;

   typedef enum logic [1:0] {
      DCR_SZ_BYTE = 2'b00,
      DCR_SZ_HALF = 2'b01,
      DCR_SZ_WORD = 2'b10
   } dcr_size_e;

   typedef struct packed {
      logic [6:0]  addr;
      dcr_size_e   size;
      logic        wr;
      logic        rd;
      logic [31:0] wdata;
   } dcr_cmd_s;

   typedef struct packed {
      logic        valid;
      logic [1:0]  chan;
      logic [31:0] src_step;
      logic [31:0] dst_step;
   } dcr_done_s;

endpackage

//--- verilog/dcr_buf2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module dcr_buf2 (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // Filling side
   input  wire logic        in_valid_i,
   input  wire logic [31:0] in_data_i,
   output logic             in_ready_o,
   // Draining side
   output logic             out_valid_o,
   output logic [31:0]      out_data_o,
   input  wire logic        out_ready_i
);

   logic        out_valid_r;
   logic [31:0] out_data_r;
   logic        skid_valid_r;
   logic [31:0] skid_data_r;

   assign in_ready_o  = ~skid_valid_r;
   assign out_valid_o = out_valid_r;
   assign out_data_o  = out_data_r;

   // ****************************************
   // Output stage and skid entry
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         out_valid_r  <= 1'b0;
         out_data_r   <= 32'h00000000;
         skid_valid_r <= 1'b0;
         skid_data_r  <= 32'h00000000;
      end else if (ce_i) begin
         if (out_ready_i || !out_valid_r) begin
            if (skid_valid_r) begin
               out_valid_r  <= 1'b1;
               out_data_r   <= skid_data_r;
               skid_valid_r <= 1'b0;
            end else begin
               out_valid_r <= in_valid_i;
               out_data_r  <= in_data_i;
            end
         end else if (in_valid_i && !skid_valid_r) begin
            skid_valid_r <= 1'b1;
            skid_data_r  <= in_data_i;
         end
      end
   end

endmodule

//--- verilog/dcr_top.sv
// Per-channel register set of a four-channel transfer controller
`timescale 1ns/1ns
`include "dcr_defines.svh"

//Function
// - Each channel holds a 32-bit read/write source pointer showing next read address.
// - Pointers and counter are undefined after reset and kept during standby.
// - Each channel holds a 32-bit counting destination pointer showing next write address.
// - Counter value one means one transfer; zero means 16,777,216 transfers.
// - Reading the counter during a transfer returns remaining transfers.
// - In 16-byte size each 128-bit block counts as one transfer.
// - Counter bits 31 to 24 ignore writes and read zero.
// - Channel control clears to zero on reset and holds through standby.
// - Bit 20 only channel 3, bit 19 only channel 2, bits 6,16-18 channels 0-1.
// - Channel control bits 31 to 21 always read zero.
// - Transfer-end flag clears only by writing zero after reading one.
// - Channel 3 pointer mode select: zero direct, one indirect.
// - Channel 2 source reload bit: zero no reload, one reload source.
// - Request-accepted output active-low when polarity bit zero, active-high when one.
// - Dual address mode strobe in read cycle when phase bit zero, else write cycle.
// - Single address mode asserts the strobe on every transfer regardless of phase bit.
// - Bit 16 makes the transfer strobe active-low when zero, active-high when one.
// - 16-bit accesses update only the addressed half, keeping the other half.
module dcr_top (
   // Clock, reset and clock enable
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  ce_i,
   // CPU register port
   input  wire dcr_pkg::dcr_cmd_s     cmd_i,
   input  wire logic                  cmd_valid_i,
   output logic                       cmd_ready_o,
   output logic [31:0]                rdata_o,
   output logic                       rvalid_o,
   input  wire logic                  rready_i,
   // Transfer engine side
   input  wire dcr_pkg::dcr_done_s    done_i,
   output logic [3:0][31:0]           source_pointer_o,
   output logic [3:0][31:0]           dest_pointer_o,
   output logic [3:0][23:0]           transfer_count_o,
   output logic [3:0][31:0]           channel_control_o,
   // External request pins, channels 0 and 1
   input  wire logic [1:0]            transfer_request_in_n_i,
   input  wire logic [1:0]            req_accepted_i,
   input  wire logic [1:0]            rd_cycle_i,
   input  wire logic [1:0]            wr_cycle_i,
   input  wire logic [1:0]            single_addr_i,
   output logic [1:0]                 transfer_request_o,
   output logic [1:0]                 request_accepted_out_o,
   output logic [1:0]                 transfer_strobe_out_o
);

   // ****************************************
   // Storage
   // ****************************************
   logic [3:0][31:0] src_r;
   logic [3:0][31:0] dst_r;
   logic [3:0][23:0] cnt_r;
   logic [3:0][31:0] ctl_r;
   logic [3:0]       end_seen_r;
   logic [31:0]      src_init_r;
   logic [1:0]       rld_cnt_r;
   logic [1:0]       req_pin_prev_r;
   logic [1:0]       req_r;
   logic [1:0]       acc_out_r;
   logic [1:0]       stb_out_r;

   // ****************************************
   // Command decode
   // ****************************************
   logic        cmd_take;
   logic        hit;
   logic [1:0]  chan;
   logic [1:0]  sel;
   logic [3:0]  be;
   logic [31:0] rd_word;
   logic        buf_ready;

   assign cmd_take = cmd_valid_i & buf_ready & ce_i;
   assign hit      = (cmd_i.addr >= `DCR_CH0_BASE) && (cmd_i.addr <= `DCR_CH_LAST);
   assign chan     = 2'(cmd_i.addr[6:4] - 3'h2);
   assign sel      = cmd_i.addr[3:2];

   // Byte lanes, big-endian: lane 3 holds bits 31:24
   always_comb begin
      be = 4'h0;
      unique case (cmd_i.size)
         dcr_pkg::DCR_SZ_BYTE: be = 4'(4'h8 >> cmd_i.addr[1:0]);
         dcr_pkg::DCR_SZ_HALF: be = cmd_i.addr[1] ? 4'h3 : 4'hC;
         dcr_pkg::DCR_SZ_WORD: be = 4'hF;
         default:              be = 4'h0;
      endcase
   end

   // Lane merge of write data into an old value
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  lanes);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (lanes[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ****************************************
   // Per-channel registers
   // ****************************************
   for (genvar c = 0; c < 4; c++) begin : g_chan
      localparam logic [31:0] WMASK = (c < 2) ? `DCR_MASK_CH01 :
                                      (c == 2) ? `DCR_MASK_CH2 : `DCR_MASK_CH3;
      logic        sel_ch;
      logic        w_src;
      logic        w_dst;
      logic        w_cnt;
      logic        w_ctl;
      logic        r_ctl;
      logic        unit_done;
      logic        end_set;
      logic        reload_now;
      logic [31:0] ctl_wr;
      logic [31:0] cnt_wr;

      assign sel_ch    = cmd_take & hit & (chan == 2'(c));
      assign w_src     = sel_ch & cmd_i.wr & (sel == `DCR_SEL_SRC);
      assign w_dst     = sel_ch & cmd_i.wr & (sel == `DCR_SEL_DST);
      assign w_cnt     = sel_ch & cmd_i.wr & (sel == `DCR_SEL_CNT);
      assign w_ctl     = sel_ch & cmd_i.wr & (sel == `DCR_SEL_CTL);
      assign r_ctl     = sel_ch & cmd_i.rd & (sel == `DCR_SEL_CTL);
      assign unit_done = ce_i & done_i.valid & (done_i.chan == 2'(c));
      assign end_set   = unit_done & (cnt_r[c] == 24'h000001);
      assign reload_now = (c == 2) & ctl_r[c][`DCR_BIT_SRC_RELOAD]
                          & (rld_cnt_r == `DCR_RELOAD_LAST);
      assign ctl_wr    = merge(ctl_r[c], cmd_i.wdata, be);
      assign cnt_wr    = merge({8'h00, cnt_r[c]}, cmd_i.wdata, be) & `DCR_CNT_MASK;

      // Source pointer, no reset so contents survive standby
      always_ff @(posedge core_clk_i) begin
         if (w_src) begin
            src_r[c] <= merge(src_r[c], cmd_i.wdata, be);
         end else if (unit_done) begin
            if (reload_now) begin
               src_r[c] <= src_init_r;
            end else begin
               src_r[c] <= src_r[c] + done_i.src_step;
            end
         end
      end

      // Destination pointer with its counting function
      always_ff @(posedge core_clk_i) begin
         if (w_dst) begin
            dst_r[c] <= merge(dst_r[c], cmd_i.wdata, be);
         end else if (unit_done) begin
            dst_r[c] <= dst_r[c] + done_i.dst_step;
         end
      end

      // Transfer counter, zero wraps to the full 2^24 count
      always_ff @(posedge core_clk_i) begin
         if (w_cnt) begin
            cnt_r[c] <= cnt_wr[23:0];
         end else if (unit_done) begin
            cnt_r[c] <= cnt_r[c] - 24'h000001;
         end
      end

      // Channel control, cleared on reset only
      always_ff @(posedge core_clk_i) begin
         if (rst_i) begin
            ctl_r[c] <= `DCR_CTL_RST;
         end else if (ce_i) begin
            if (w_ctl) begin
               ctl_r[c] <= (ctl_wr & WMASK) | (ctl_r[c] & ~WMASK & 32'h00000002);
            end
            if (end_set) begin
               ctl_r[c][`DCR_BIT_END_FLAG] <= 1'b1;
            end else if (w_ctl && be[0] && end_seen_r[c]
                         && !cmd_i.wdata[`DCR_BIT_END_FLAG]) begin
               ctl_r[c][`DCR_BIT_END_FLAG] <= 1'b0;
            end
         end
      end

      // Read of a set end flag arms its clear
      always_ff @(posedge core_clk_i) begin
         if (rst_i) begin
            end_seen_r[c] <= 1'b0;
         end else if (ce_i) begin
            if (r_ctl && ctl_r[c][`DCR_BIT_END_FLAG]) begin
               end_seen_r[c] <= 1'b1;
            end else if (w_ctl && be[0] && !cmd_i.wdata[`DCR_BIT_END_FLAG]) begin
               end_seen_r[c] <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // Channel 2 source reload
   // ****************************************
   logic w_src2;
   logic done2;

   assign w_src2 = cmd_take & hit & cmd_i.wr & (chan == 2'h2) & (sel == `DCR_SEL_SRC);
   assign done2  = ce_i & done_i.valid & (done_i.chan == 2'h2);

   always_ff @(posedge core_clk_i) begin
      if (w_src2) begin
         src_init_r <= merge(src_r[2], cmd_i.wdata, be);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rld_cnt_r <= 2'h0;
      end else if (w_src2) begin
         rld_cnt_r <= 2'h0;
      end else if (done2 && ctl_r[2][`DCR_BIT_SRC_RELOAD]) begin
         rld_cnt_r <= rld_cnt_r + 2'h1;
      end
   end

   // ****************************************
   // Read data and two-entry return buffer
   // ****************************************
   always_comb begin
      rd_word = 32'h00000000;
      if (hit) begin
         unique case (sel)
            `DCR_SEL_SRC: rd_word = src_r[chan];
            `DCR_SEL_DST: rd_word = dst_r[chan];
            `DCR_SEL_CNT: rd_word = {8'h00, cnt_r[chan]};
            `DCR_SEL_CTL: rd_word = ctl_r[chan];
         endcase
      end
   end

   dcr_buf2 u_rbuf (
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .ce_i        (ce_i),
      .in_valid_i  (cmd_valid_i & cmd_i.rd),
      .in_data_i   (rd_word),
      .in_ready_o  (buf_ready),
      .out_valid_o (rvalid_o),
      .out_data_o  (rdata_o),
      .out_ready_i (rready_i)
   );

   assign cmd_ready_o = buf_ready;

   // ****************************************
   // Pin logic, channels 0 and 1
   // ****************************************
   for (genvar j = 0; j < 2; j++) begin : g_pin
      logic stb_act;

      assign stb_act = single_addr_i[j] ? (rd_cycle_i[j] | wr_cycle_i[j]) :
                       (ctl_r[j][`DCR_BIT_ACK_PHASE] ? wr_cycle_i[j] : rd_cycle_i[j]);

      always_ff @(posedge core_clk_i) begin
         if (rst_i) begin
            stb_out_r[j]      <= 1'b1;
            acc_out_r[j]      <= 1'b1;
            req_pin_prev_r[j] <= 1'b1;
            req_r[j]          <= 1'b0;
         end else if (ce_i) begin
            stb_out_r[j]      <= ctl_r[j][`DCR_BIT_STB_POL] ? stb_act : ~stb_act;
            acc_out_r[j]      <= ctl_r[j][`DCR_BIT_ACC_POL] ? req_accepted_i[j]
                                                            : ~req_accepted_i[j];
            req_pin_prev_r[j] <= transfer_request_in_n_i[j];
            req_r[j]          <= ctl_r[j][`DCR_BIT_REQ_SENSE] ?
                                 (req_pin_prev_r[j] & ~transfer_request_in_n_i[j]) :
                                 ~transfer_request_in_n_i[j];
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign source_pointer_o       = src_r;
   assign dest_pointer_o         = dst_r;
   assign transfer_count_o       = cnt_r;
   assign channel_control_o      = ctl_r;
   assign transfer_request_o     = req_r;
   assign request_accepted_out_o = acc_out_r;
   assign transfer_strobe_out_o  = stb_out_r;

endmodule

//--- dv/dcr_top_monitor.sv
// Concurrent checks on the channel register set ports
`timescale 1ns/1ns
module dcr_top_monitor (
   // Clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   // Register port
   input  wire dcr_pkg::dcr_cmd_s cmd_i,
   input  wire logic             cmd_valid_i,
   input  wire logic             cmd_ready_o,
   input  wire logic [31:0]      rdata_o,
   input  wire logic             rvalid_o,
   input  wire logic             rready_i,
   // Engine side and pins
   input  wire dcr_pkg::dcr_done_s done_i,
   input  wire logic [3:0][31:0] dest_pointer_o,
   input  wire logic [3:0][23:0] transfer_count_o,
   input  wire logic [3:0][31:0] channel_control_o,
   input  wire logic [1:0]       req_accepted_i,
   input  wire logic [1:0]       rd_cycle_i,
   input  wire logic [1:0]       wr_cycle_i,
   input  wire logic [1:0]       single_addr_i,
   input  wire logic [1:0]       request_accepted_out_o,
   input  wire logic [1:0]       transfer_strobe_out_o
);
   // ****************
   // Helpers
   // ****************
   logic [1:0] acc_pol_w;
   logic [1:0] phase_w;
   logic [1:0] stb_pol_w;
   logic [1:0] act_w;
   logic       tk_w;
   logic [2:0] ch_a_w;
   logic [31:0] c0_w;
   logic [31:0] c1_w;
   logic [31:0] c2_w;
   logic [31:0] c3_w;
   assign c0_w = channel_control_o[0];
   assign c1_w = channel_control_o[1];
   assign c2_w = channel_control_o[2];
   assign c3_w = channel_control_o[3];
   assign acc_pol_w = {c1_w[18], c0_w[18]};
   assign phase_w = {c1_w[17], c0_w[17]};
   assign stb_pol_w = {c1_w[16], c0_w[16]};
   assign act_w = (single_addr_i & (rd_cycle_i | wr_cycle_i))
                | (~single_addr_i & ((phase_w & wr_cycle_i) | (~phase_w & rd_cycle_i)));
   assign tk_w = ce_i && cmd_valid_i && cmd_ready_o && cmd_i.wr;
   assign ch_a_w = {1'b0, done_i.chan} + 3'h2;

   // ****************
   // Checks
   // ****************
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_done;
      ce_i && done_i.valid;
   endsequence
   sequence s_rd_take;
      ce_i && cmd_valid_i && cmd_ready_o && cmd_i.rd && !rvalid_o;
   endsequence
   AST_CTL_RSV: assert property ({c0_w[31:21], c1_w[31:21], c2_w[31:21], c3_w[31:21]} == 44'h0)
      else $error("reserved control bits set");
   AST_CTL_UNUSED: assert property ({c0_w[20:19], c1_w[20:19], c2_w[20], c2_w[18:16],
      c2_w[6], c3_w[19:16], c3_w[6]} == 14'h0)
      else $error("absent control bit set");
   AST_CTL_RST: assert property ($past(rst_i && ce_i) |-> channel_control_o == 128'h0)
      else $error("control not cleared by reset");
   AST_ACC_OUT: assert property ($past(ce_i && !rst_i)
      |-> request_accepted_out_o == $past(req_accepted_i ~^ acc_pol_w))
      else $error("accept output level wrong");
   AST_ACK_DUAL: assert property ($past(ce_i && !rst_i && !single_addr_i[0])
      |-> transfer_strobe_out_o[0] == $past(act_w[0] ~^ stb_pol_w[0]))
      else $error("dual address strobe wrong");
   AST_ACK_SINGLE: assert property ($past(ce_i && !rst_i && single_addr_i[1])
      |-> transfer_strobe_out_o[1] == $past(act_w[1] ~^ stb_pol_w[1]))
      else $error("single address strobe wrong");
   AST_RD_ANSWER: assert property (s_rd_take |=> rvalid_o)
      else $error("read answer late");
   AST_RD_HOLD: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
      else $error("read data not held");
   AST_CNT_DEC: assert property (s_done ##0 !(tk_w && cmd_i.addr[6:2] == {ch_a_w, 2'h2})
      |=> transfer_count_o[$past(done_i.chan)] == $past(transfer_count_o[done_i.chan]) - 24'h1)
      else $error("count did not step down");
   AST_DST_STEP: assert property (s_done ##0 !(tk_w && cmd_i.addr[6:2] == {ch_a_w, 2'h1})
      |=> dest_pointer_o[$past(done_i.chan)]
          == $past(dest_pointer_o[done_i.chan] + done_i.dst_step))
      else $error("destination did not step");
   AST_END_NOSET: assert property (ce_i && !c0_w[1] && !(done_i.valid && done_i.chan == 2'h0)
      |=> !c0_w[1])
      else $error("end flag set without transfer end");
endmodule

bind dcr_top dcr_top_monitor u_dcr_top_monitor (.core_clk_i, .rst_i, .ce_i, .cmd_i,
   .cmd_valid_i, .cmd_ready_o, .rdata_o, .rvalid_o, .rready_i, .done_i, .dest_pointer_o,
   .transfer_count_o, .channel_control_o, .req_accepted_i, .rd_cycle_i, .wr_cycle_i,
   .single_addr_i, .request_accepted_out_o, .transfer_strobe_out_o);

//--- dv/dcr_ext_dev.sv
// Behavioural model of the two external requesting devices
`timescale 1ns/1ns
module dcr_ext_dev (
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   // Demand and strobe seen at its active level
   input  wire logic [1:0] want_i,
   input  wire logic [1:0] strobe_act_i,
   // Request pins, pulled up when released
   output logic [1:0]      req_n_o = 2'h3
);
   // Request held low until the strobe is seen
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         req_n_o <= 2'h3;
      end else begin
         req_n_o <= ~want_i | strobe_act_i;
      end
   end
endmodule

//--- dv/test_dma_channel_register_set.sv
// Self-checking bench of the channel register set
`timescale 1ns/1ns
`include "dcr_defines.svh"
module test_dma_channel_register_set;
   logic               core_clk_i = 1'b0;
   logic               rst_i = 1'b1;
   logic               ce_i = 1'b1;
   dcr_pkg::dcr_cmd_s  cmd_i = '0;
   logic               cmd_valid_i = 1'b0;
   logic               rready_i = 1'b1;
   dcr_pkg::dcr_done_s done_i = '0;
   logic [1:0]         req_accepted_i = 2'h0;
   logic [1:0]         rd_cycle_i = 2'h0;
   logic [1:0]         wr_cycle_i = 2'h0;
   logic [1:0]         single_addr_i = 2'h0;
   logic [1:0]         want = 2'h0;
   logic [1:0]         transfer_request_in_n_i;
   logic               cmd_ready_o;
   logic               rvalid_o;
   logic [31:0]        rdata_o;
   logic [3:0][31:0]   source_pointer_o;
   logic [3:0][31:0]   dest_pointer_o;
   logic [3:0][23:0]   transfer_count_o;
   logic [3:0][31:0]   channel_control_o;
   logic [1:0]         transfer_request_o;
   logic [1:0]         request_accepted_out_o;
   logic [1:0]         transfer_strobe_out_o;
   logic [1:0]         stb_act;
   int                 n_fail = 0;
   int                 num_checks = 0;

   always #10 core_clk_i = ~core_clk_i;
   assign stb_act = transfer_strobe_out_o ~^ {channel_control_o[1][16], channel_control_o[0][16]};

   dcr_top u_dcr_top (.core_clk_i, .rst_i, .ce_i, .cmd_i, .cmd_valid_i, .cmd_ready_o,
      .rdata_o, .rvalid_o, .rready_i, .done_i, .source_pointer_o, .dest_pointer_o,
      .transfer_count_o, .channel_control_o, .transfer_request_in_n_i, .req_accepted_i,
      .rd_cycle_i, .wr_cycle_i, .single_addr_i, .transfer_request_o,
      .request_accepted_out_o, .transfer_strobe_out_o);
   dcr_ext_dev u_dcr_ext_dev (.core_clk_i, .rst_i, .want_i(want), .strobe_act_i(stb_act),
      .req_n_o(transfer_request_in_n_i));

   // ****************
   // Tasks
   // ****************
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick;
      @(posedge core_clk_i);
      #1;
   endtask
   task automatic wait_hi(input int k);
      int i;
      for (i = 0; i < 50 && (k ? rvalid_o : cmd_ready_o) !== 1'b1; i++) begin
         tick();
      end
      if (i == 50) begin
         chk("wait", 32'h0, 32'h1);
         end_sim();
      end
   endtask
   task automatic cyc(input logic [6:0] a, input logic [1:0] sz, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
      cmd_i = {a, sz, w, ~w, d};
      cmd_valid_i = 1'b1;
      wait_hi(0);
      tick();
      cmd_valid_i = 1'b0;
      q = 32'h0;
      if (!w) begin
         wait_hi(1);
         q = rdata_o;
      end
      tick();
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      logic [31:0] q;
      cyc(a, 2'h2, 1'b1, d, q);
   endtask
   task automatic rdc(input string nm, input logic [6:0] a, input logic [31:0] e);
      logic [31:0] q;
      cyc(a, 2'h2, 1'b0, 32'h0, q);
      chk(nm, q, e);
   endtask
   task automatic step(input logic [1:0] c, input logic [31:0] s, input logic [31:0] d);
      done_i = {1'b1, c, s, d};
      tick();
      done_i.valid = 1'b0;
      tick();
   endtask
   function automatic logic [6:0] ad(input int c, input int r);
      return 7'(32 + 16 * c + 4 * r);
   endfunction
   function automatic logic [31:0] exp_ctl(input int c, input logic [31:0] v);
      return v & (c < 2 ? `DCR_MASK_CH01 : c == 2 ? `DCR_MASK_CH2 : `DCR_MASK_CH3);
   endfunction
   function automatic logic [1:0] exp_stb(input logic [1:0] am, input logic [1:0] al);
      logic [1:0] act;
      act = (single_addr_i & (rd_cycle_i | wr_cycle_i))
          | (~single_addr_i & ((am & wr_cycle_i) | (~am & rd_cycle_i)));
      return act ~^ al;
   endfunction

   // ****************
   // Sequence
   // ****************
   initial begin
      logic [31:0] r;
      logic [31:0] s;
      logic [31:0] d;
      int c;
      int k;
      void'($urandom(32'h5B701FEA));
      repeat (4) tick();
      rst_i = 1'b0;
      for (c = 0; c < 4; c++) begin
         rdc("ctl_rst", ad(c, 3), 32'h0);
      end
      wr(7'h10, 32'hFFFFFFFF);
      rdc("unmapped", 7'h10, 32'h0);
      $display("test reset done");
      for (k = 0; k < 12; k++) begin
         r = (k < 4) ? 32'hFFFFFFFF : $urandom;
         wr(ad(k % 4, 3), r);
         rdc("ctl", ad(k % 4, 3), exp_ctl(k % 4, r));
      end
      $display("test control done");
      for (c = 0; c < 4; c++) begin
         s = $urandom;
         d = $urandom;
         r = $urandom;
         wr(ad(c, 0), s);
         wr(ad(c, 1), d);
         wr(ad(c, 2), r);
         rdc("src", ad(c, 0), s);
         chk("src_out", source_pointer_o[c], s);
         rdc("dst", ad(c, 1), d);
         rdc("cnt", ad(c, 2), r & `DCR_CNT_MASK);
         cyc(ad(c, 0) + 7'h2, 2'h1, 1'b1, {2{r[15:0]}}, d);
         rdc("half", ad(c, 0), {s[31:16], r[15:0]});
      end
      $display("test pointers done");
      wr(ad(1, 2), 32'h2);
      wr(ad(1, 1), 32'h1000);
      step(2'h1, 32'h4, 32'h4);
      rdc("cnt_dec", ad(1, 2), 32'h1);
      rdc("dst_step", ad(1, 1), 32'h1004);
      step(2'h1, 32'h4, 32'h4);
      wr(ad(1, 3), 32'h0);
      rdc("end_kept", ad(1, 3), 32'h2);
      wr(ad(1, 3), 32'h0);
      rdc("end_clr", ad(1, 3), 32'h0);
      step(2'h1, 32'h4, 32'h4);
      rdc("wrap", ad(1, 2), 32'h00FFFFFF);
      $display("test count done");
      wr(ad(2, 3), 32'h00080000);
      s = $urandom & 32'hFFFFFFFC;
      wr(ad(2, 0), s);
      for (k = 1; k <= 5; k++) begin
         step(2'h2, 32'h4, 32'h0);
         rdc("reload", ad(2, 0), s + 32'h4 * (k % 4));
      end
      wr(ad(2, 3), 32'h0);
      wr(ad(2, 0), s);
      repeat (4) step(2'h2, 32'h4, 32'h0);
      rdc("no_reload", ad(2, 0), s + 32'h10);
      $display("test reload done");
      for (k = 0; k < 24; k++) begin
         r = $urandom & 32'h00070000;
         wr(ad(0, 3), r);
         wr(ad(1, 3), r ^ 32'h00070000);
         {want, req_accepted_i, rd_cycle_i, wr_cycle_i, single_addr_i} = 10'($urandom);
         repeat (4) tick();
         chk("acc_out", request_accepted_out_o, 2'(req_accepted_i ~^ {~r[18], r[18]}));
         chk("strobe", transfer_strobe_out_o, exp_stb({~r[17], r[17]}, {~r[16], r[16]}));
         chk("req", transfer_request_o, 2'(~transfer_request_in_n_i));
      end
      wr(ad(0, 3), 32'h00000040);
      {want, rd_cycle_i, wr_cycle_i, single_addr_i} = 8'h00;
      repeat (3) tick();
      want = 2'h1;
      repeat (2) tick();
      chk("edge", transfer_request_o[0], 32'h1);
      tick();
      chk("edge_once", transfer_request_o[0], 32'h0);
      $display("test pins done");
      ce_i = 1'b0;
      step(2'h1, 32'h4, 32'h4);
      ce_i = 1'b1;
      rdc("standby", ad(1, 2), 32'h00FFFFFF);
      rdc("standby_ctl", ad(1, 3), exp_ctl(1, r ^ 32'h00070000));
      $display("test standby done");
      rready_i = 1'b0;
      cmd_i = {ad(1, 2), 2'h2, 1'b0, 1'b1, 32'h0};
      cmd_valid_i = 1'b1;
      for (k = 0; k < 2; k++) begin
         wait_hi(0);
         tick();
      end
      cmd_valid_i = 1'b0;
      chk("full", cmd_ready_o, 32'h0);
      rready_i = 1'b1;
      for (k = 0; k < 2; k++) begin
         wait_hi(1);
         chk("drain", rdata_o, 32'h00FFFFFF);
         tick();
      end
      chk("ready", cmd_ready_o, 32'h1);
      $display("test buffer done");
      end_sim();
   end
endmodule
